//--- bench/host_bus_port_props.sv
`timescale 1ns/1ns
module host_bus_port_props (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       nrst_i,
    // Host bus
    input wire logic       ale_i,
    input wire logic       rd_n_i,
    input wire logic       wr_n_i,
    input wire logic       cs_n_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o,
    // Control outputs
    input wire logic [7:0] mode_register_o,
    input wire logic [7:0] command_register_o,
    input wire logic       section_reset_o
);
    logic       ale_q;
    logic       wr_n_q;
    logic [3:0] addr_q;
    logic [7:0] wd_q;
    logic       take;
    // Shadow of the latched address and of the last written byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ale_q <= 1'b0;
            wr_n_q <= 1'b1;
            addr_q <= 4'h0;
            wd_q <= 8'h00;
        end else begin
            ale_q <= ale_i;
            wr_n_q <= wr_n_i;
            if (ale_q && !ale_i) begin
                addr_q <= data_i[3:0];
            end
            if (take) begin
                wd_q <= data_i;
            end
        end
    end
    // End of a qualified write
    assign take = wr_n_i && !wr_n_q && !cs_n_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_read_drives_bus: assert property (!rd_n_i && !cs_n_i |=> data_oe_o)
        else $error("bus not driven during read");
    a_bus_quiet_idle: assert property (rd_n_i |=> !data_oe_o)
        else $error("bus driven without read");
    a_oe_has_cause: assert property (data_oe_o |-> $past(!rd_n_i && !cs_n_i))
        else $error("bus driven without chip select");
    a_mode_write: assert property (take && addr_q == 4'h2 && !section_reset_o
        |-> ##[1:2] mode_register_o == wd_q) else $error("mode write lost");
    a_status_readonly: assert property (take && addr_q == 4'h0
        |=> $stable(mode_register_o)[*2]) else $error("status write leaked");
    a_ignore_no_cs: assert property (wr_n_i && !wr_n_q && cs_n_i
        |=> $stable(mode_register_o)) else $error("write taken without select");
    a_soft_start: assert property (take && addr_q == 4'h3 && data_i[5]
        && !section_reset_o |-> ##[1:3] section_reset_o) else $error("no soft reset");
    a_soft_length: assert property ($rose(section_reset_o) |-> section_reset_o[*8])
        else $error("soft reset too short");
    a_soft_clears: assert property ($fell(section_reset_o) |-> ##[0:2]
        (command_register_o == 8'h00 && mode_register_o == 8'h00))
        else $error("registers not cleared");
    a_read_mode: assert property (data_oe_o && $past(addr_q) == 4'h2
        |-> data_o == $past(mode_register_o)) else $error("mode read wrong");
endmodule

//--- bench/host_bus_register_access_and_reset_tb.sv
`timescale 1ns/1ns
module host_bus_register_access_and_reset_tb;
    logic        clk_i, nrst_i, ale, rd_n, wr_n, cs_n, oe, mv, lb, bb, tb, rr, srst;
    logic [7:0]  dbus, dout, rdat, mode, cmd;
    logic [11:0] mbits;
    logic [3:0]  mlen;
    int          err_count = 0;
    int          checked = 0;
    localparam logic [11:0] M1 = 12'habc;
    localparam logic [3:0]  L1 = 4'h9;
    host_cpu_model cpu_inst (.clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(oe), .ale_o(ale),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n), .bus_o(dbus), .rd_data_o(rdat));
    host_bus_port host_bus_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .ale_i(ale),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .cs_n_i(cs_n), .data_i(dbus), .data_o(dout),
        .data_oe_o(oe), .bus_a_msg_valid_i(mv), .bus_a_msg_bits_i(mbits),
        .bus_a_msg_len_i(mlen), .line_tx_busy_i(lb), .bus_b_tx_busy_i(bb),
        .tape_tx_busy_i(tb), .serial_bus_b_receiver_ready_i(rr), .mode_register_o(mode),
        .command_register_o(cmd), .section_reset_o(srst));
    // Comparison and register read helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] exp, input string what);
        cpu_inst.latch(a);
        cpu_inst.rd();
        chk(what, exp, rdat);
    endtask
    task automatic t_reset();
        rreg(host_port_pkg::ADDR_STATUS_LOW, host_port_pkg::STATUS_LOW_RESET, "stat lo");
        chk("lo masked", host_port_pkg::STATUS_LOW_RESET & 8'h07, rdat & 8'h07);
        rreg(host_port_pkg::ADDR_STATUS_HIGH, host_port_pkg::STATUS_HIGH_RESET, "stat hi");
        rreg(host_port_pkg::ADDR_MODE, 8'h00, "mode");
        rreg(host_port_pkg::ADDR_COMMAND, 8'h00, "command");
        $display("reset test done");
    endtask
    task automatic t_regs();
        cpu_inst.latch(host_port_pkg::ADDR_MODE);
        cpu_inst.wr(8'h5a, 1'b1);
        cpu_inst.wr(8'h33, 1'b0);
        cpu_inst.rd();
        chk("mode back", 8'h5a, rdat);
        chk("mode out", 8'h5a, mode);
        cpu_inst.latch(host_port_pkg::ADDR_STATUS_LOW);
        cpu_inst.wr(8'h00, 1'b1);
        cpu_inst.rd();
        chk("stat ro", host_port_pkg::STATUS_LOW_RESET, rdat);
        rreg(4'h5, 8'h00, "unmapped");
        $display("register test done");
    endtask
    task automatic t_status();
        {lb, bb, tb, rr} = 4'b1111;
        rreg(host_port_pkg::ADDR_STATUS_LOW, 8'h00, "busy lo");
        rreg(host_port_pkg::ADDR_STATUS_HIGH, 8'h02, "busy hi");
        {lb, bb, tb, rr} = 4'b0000;
        $display("status test done");
    endtask
    task automatic t_soft();
        cpu_inst.latch(host_port_pkg::ADDR_COMMAND);
        cpu_inst.wr(8'h20, 1'b1);
        cpu_inst.rd();
        chk("cmd busy", 8'h20, rdat);
        chk("cmd out", 8'h20, cmd);
        chk("sect busy", 8'h01, {7'h00, srst});
        repeat (12) @(negedge clk_i);
        rreg(host_port_pkg::ADDR_COMMAND, 8'h00, "cmd done");
        rreg(host_port_pkg::ADDR_MODE, 8'h00, "mode clr");
        chk("sect done", 8'h00, {7'h00, srst});
        rreg(host_port_pkg::ADDR_STATUS_LOW, host_port_pkg::STATUS_LOW_RESET, "lo soft");
        $display("soft reset test done");
    endtask
    task automatic t_rx();
        @(negedge clk_i);
        {mbits, mlen, mv} = {M1, L1, 1'b1};
        @(negedge clk_i);
        {mbits, mv} = {12'h123, 1'b0};
        @(negedge clk_i);
        mv = 1'b1;
        @(negedge clk_i);
        mv = 1'b0;
        rreg(host_port_pkg::ADDR_STATUS_LOW, 8'h07, "rx ready");
        cpu_inst.latch(host_port_pkg::ADDR_BUS_A_RX);
        cpu_inst.rd();
        // First byte: L-4 at bit 7 down to L-11 at bit 0
        chk("rx first", 8'hd5, rdat);
        cpu_inst.rd();
        // Second byte: length, then L at bit 3 down to L-3 at bit 0
        chk("rx second", {L1, 4'h3}, rdat);
        rreg(host_port_pkg::ADDR_STATUS_LOW, 8'h05, "rx clear");
        $display("receive test done");
    endtask
    task automatic t_hw();
        cpu_inst.latch(host_port_pkg::ADDR_MODE);
        cpu_inst.wr(8'h3c, 1'b1);
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("mode async", 8'h00, mode);
        chk("sect async", 8'h01, {7'h00, srst});
        nrst_i = 1'b1;
        rreg(host_port_pkg::ADDR_MODE, 8'h00, "mode hw");
        rreg(host_port_pkg::ADDR_STATUS_HIGH, host_port_pkg::STATUS_HIGH_RESET, "hi hw");
        $display("hardware reset test done");
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        {nrst_i, mv, lb, bb, tb, rr, mbits, mlen} = '0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_regs();
        t_status();
        t_soft();
        t_rx();
        t_hw();
        results();
    end
    // Watchdog, well beyond the 169 cycles the tests take
    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
bind host_bus_port host_bus_port_props host_bus_port_props_inst (.clk_i(clk_i),
    .nrst_i(nrst_i), .ale_i(ale_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .cs_n_i(cs_n_i),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .mode_register_o(mode_register_o), .command_register_o(command_register_o),
    .section_reset_o(section_reset_o));

//--- bench/host_cpu_model.sv
`timescale 1ns/1ns
module host_cpu_model (
    // Clock and device side of the bus
    input  wire logic       clk_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_i,
    // Bus strobes and wire level
    output logic            ale_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            cs_n_o,
    output logic [7:0]      bus_o,
    output logic [7:0]      rd_data_o
);
    logic       drv_en;
    logic [7:0] drv;
    // Wire level: the host driver, else the device when enabled, else the inverse of the host's last value
    assign bus_o = drv_en ? drv : (dev_oe_i ? dev_data_i : ~drv);
    initial begin
        {ale_o, drv_en, drv, rd_data_o} = '0;
        {rd_n_o, wr_n_o, cs_n_o} = 3'b111;
    end
    // Address phase on the low four lines, upper lines zero
    task automatic latch(input logic [3:0] a);
        @(negedge clk_i);
        ale_o = 1'b1;
        drv = {4'h0, a};
        drv_en = 1'b1;
        @(negedge clk_i);
        ale_o = 1'b0;
        @(negedge clk_i);
        drv_en = 1'b0;
    endtask
    // Write held until the strobe has risen under chip select
    task automatic wr(input logic [7:0] d, input logic sel);
        @(negedge clk_i);
        drv = d;
        drv_en = 1'b1;
        cs_n_o = !sel;
        wr_n_o = 1'b0;
        @(negedge clk_i);
        wr_n_o = 1'b1;
        @(negedge clk_i);
        cs_n_o = 1'b1;
        drv_en = 1'b0;
    endtask
    // Read, one access per byte of a pair
    task automatic rd();
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        rd_data_o = bus_o;
        rd_n_o = 1'b1;
        @(negedge clk_i);
        cs_n_o = 1'b1;
    endtask
endmodule

//--- hdl/host_bus_port.sv
`timescale 1ns/1ns
// Function
// - Asynchronous reset input brings every register to default without host action.
// - Writing command bit 5 starts soft reset; hardware clears it when done.
// - After any reset mode and command read zero; status reads its reset value (viewdata defaults).
// - Transmitter ready flags in both status registers read one after reset.
// - Fifteen registers reached through eleven addresses; this block hosts core ones.
// - Two-level registers move both bytes by consecutive same-address accesses.
// - Shared address: reads return read-only register, writes update write-only one.
// - One bidirectional 8-bit data port carries both address and data.
// - Read and write strobes count only while chip select is active.
// - Exactly one register meets the internal bus per qualified access.
// - Address latched from four low data lines at falling edge of ALE.
// - Data line 3 is address MSB, line 0 LSB; value is register number.
// - Status registers read only; mode and command read and write.
// - Bus A receive pair: first byte bits L-4..L-11, second length and last four.
// - Reading receive pair clears ready flag; flag blocks overwriting of holding pair.
module host_bus_port (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Host bus, active-high ALE and active-low strobes
    input  wire logic        ale_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        cs_n_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    // Serial bus A receiver message
    input  wire logic        bus_a_msg_valid_i,
    input  wire logic [11:0] bus_a_msg_bits_i,
    input  wire logic [3:0]  bus_a_msg_len_i,
    // Status from the serial sections
    input  wire logic        line_tx_busy_i,
    input  wire logic        bus_b_tx_busy_i,
    input  wire logic        tape_tx_busy_i,
    input  wire logic        serial_bus_b_receiver_ready_i,
    // Control outputs
    output logic      [7:0]  mode_register_o,
    output logic      [7:0]  command_register_o,
    output logic             section_reset_o
);

    logic        ale_q;
    logic        rd_n_q;
    logic        wr_n_q;
    logic [3:0]  addr_q;
    logic [7:0]  mode_q;
    logic [7:0]  command_q;
    logic        line_transmitter_ready_q;
    logic        serial_bus_b_transmitter_ready_q;
    logic        tape_transmitter_ready_q;
    logic        serial_bus_a_receiver_ready_q;
    logic [7:0]  bus_a_receive_first_byte_q;
    logic [7:0]  bus_a_receive_second_byte_q;
    logic        byte_ptr_q;
    logic [7:0]  data_q;
    logic        data_oe_q;
    logic        soft_busy;
    logic        soft_done;
    logic        soft_start;
    logic        rd_strobe;
    logic        wr_strobe;
    logic        rd_end;
    logic        sel_rx_a;
    logic [7:0]  status_low;
    logic [7:0]  status_high;
    logic [11:0] rx_order;

    // Strobes qualified by chip select, write and read acted on at their rising end
    assign rd_strobe  = !rd_n_i && !cs_n_i;
    assign wr_strobe  = wr_n_i && !wr_n_q && !cs_n_i;
    assign rd_end     = rd_n_i && !rd_n_q && !cs_n_i;
    assign sel_rx_a   = (addr_q == host_port_pkg::ADDR_BUS_A_RX);
    assign soft_start = wr_strobe && (addr_q == host_port_pkg::ADDR_COMMAND)
                        && data_i[host_port_pkg::CMD_SOFT_RESET_BIT];

    // Message bits reordered so the oldest bit lands lowest in each byte
    for (genvar i = 0; i < 12; i++) begin : g_rx_order
        assign rx_order[i] = bus_a_msg_bits_i[11 - i];
    end

    reset_sequencer reset_sequencer_inst (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .start_i (soft_start),
        .busy_o  (soft_busy),
        .done_o  (soft_done)
    );

    // Previous levels of the host strobes for edge detection
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ale_q  <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            ale_q  <= ale_i;
            rd_n_q <= rd_n_i;
            wr_n_q <= wr_n_i;
        end
    end

    // Address latch, taken only on the falling edge of ALE
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_q <= 4'h0;
        end else if (ale_q && !ale_i) begin
            addr_q <= data_i[3:0];
        end
    end

    // Mode and command registers, cleared by either reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q    <= host_port_pkg::RESET_ZERO;
            command_q <= host_port_pkg::RESET_ZERO;
        end else if (soft_done) begin
            mode_q    <= host_port_pkg::RESET_ZERO;
            command_q <= host_port_pkg::RESET_ZERO;
        end else if (wr_strobe && !soft_busy) begin
            if (addr_q == host_port_pkg::ADDR_MODE) begin
                mode_q <= data_i;
            end else if (addr_q == host_port_pkg::ADDR_COMMAND) begin
                command_q <= data_i;
            end
        end
    end

    // Transmitter ready flags, high in hardware reset, forced low during soft reset, else not busy
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_transmitter_ready_q         <= 1'b1;
            serial_bus_b_transmitter_ready_q <= 1'b1;
            tape_transmitter_ready_q         <= 1'b1;
        end else if (soft_busy) begin
            line_transmitter_ready_q         <= 1'b0;
            serial_bus_b_transmitter_ready_q <= 1'b0;
            tape_transmitter_ready_q         <= 1'b0;
        end else begin
            line_transmitter_ready_q         <= !line_tx_busy_i;
            serial_bus_b_transmitter_ready_q <= !bus_b_tx_busy_i;
            tape_transmitter_ready_q         <= !tape_tx_busy_i;
        end
    end

    // Bus A receive holding pair and its ready flag; soft reset wins, then a new message over the read clear, a message arriving while ready is set is dropped
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_bus_a_receiver_ready_q <= 1'b0;
            bus_a_receive_first_byte_q    <= 8'h00;
            bus_a_receive_second_byte_q   <= 8'h00;
        end else if (soft_busy) begin
            serial_bus_a_receiver_ready_q <= 1'b0;
        end else if (bus_a_msg_valid_i && !serial_bus_a_receiver_ready_q) begin
            serial_bus_a_receiver_ready_q <= 1'b1;
            bus_a_receive_first_byte_q    <= rx_order[7:0];
            bus_a_receive_second_byte_q   <= {bus_a_msg_len_i, rx_order[11:8]};
        end else if (rd_end && sel_rx_a && byte_ptr_q) begin
            serial_bus_a_receiver_ready_q <= 1'b0;
        end
    end

    // Byte pointer for the two-level register, reset on new address
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            byte_ptr_q <= 1'b0;
        end else if (ale_q && !ale_i) begin
            byte_ptr_q <= 1'b0;
        end else if (rd_end && sel_rx_a) begin
            byte_ptr_q <= !byte_ptr_q;
        end
    end

    // Status bytes; unallocated bits read as zero
    assign status_low  = {5'h00, tape_transmitter_ready_q,
                          serial_bus_a_receiver_ready_q, line_transmitter_ready_q};
    assign status_high = {6'h00, serial_bus_b_receiver_ready_i,
                          serial_bus_b_transmitter_ready_q};

    // Read mux, one register driven per access
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_q    <= 8'h00;
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= rd_strobe;
            if (addr_q == host_port_pkg::ADDR_STATUS_LOW) begin
                data_q <= status_low;
            end else if (addr_q == host_port_pkg::ADDR_STATUS_HIGH) begin
                data_q <= status_high;
            end else if (addr_q == host_port_pkg::ADDR_MODE) begin
                data_q <= mode_q;
            end else if (addr_q == host_port_pkg::ADDR_COMMAND) begin
                data_q <= command_q;
            end else if (sel_rx_a) begin
                data_q <= byte_ptr_q ? bus_a_receive_second_byte_q
                                     : bus_a_receive_first_byte_q;
            end else begin
                data_q <= 8'h00;
            end
        end
    end

    // Registered control outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            section_reset_o <= 1'b1;
        end else begin
            section_reset_o <= soft_busy;
        end
    end

    assign data_o             = data_q;
    assign data_oe_o          = data_oe_q;
    assign mode_register_o    = mode_q;
    assign command_register_o = command_q;

endmodule

//--- hdl/reset_sequencer.sv
`timescale 1ns/1ns
module reset_sequencer (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Request and progress
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    host_port_pkg::reset_state_t state_q;
    logic [3:0]                  count_q;

    // Counts out the software reset sequence, then pulses done
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= host_port_pkg::RST_IDLE;
            count_q <= 4'h0;
        end else begin
            case (state_q)
                host_port_pkg::RST_IDLE: begin
                    if (start_i) begin
                        state_q <= host_port_pkg::RST_RUN;
                        count_q <= 4'h0;
                    end
                end
                host_port_pkg::RST_RUN: begin
                    count_q <= count_q + 4'h1;
                    if (count_q == host_port_pkg::RESET_SEQ_CYCLES - 4'h1) begin
                        state_q <= host_port_pkg::RST_DONE;
                    end
                end
                default: begin
                    state_q <= host_port_pkg::RST_IDLE;
                end
            endcase
        end
    end

    assign busy_o = (state_q == host_port_pkg::RST_RUN);
    assign done_o = (state_q == host_port_pkg::RST_DONE);

endmodule

//--- inc/host_port_pkg.sv
package host_port_pkg;

    // Register numbers, as latched from the low four data lines
    localparam logic [3:0] ADDR_STATUS_LOW   = 4'h0;
    localparam logic [3:0] ADDR_STATUS_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_MODE         = 4'h2;
    localparam logic [3:0] ADDR_COMMAND      = 4'h3;
    localparam logic [3:0] ADDR_BUS_A_RX     = 4'ha;
    localparam logic [3:0] ADDR_ADDR_WIDTH   = 4'h4;

    // Field positions
    localparam int unsigned CMD_SOFT_RESET_BIT  = 5;
    localparam int unsigned STAT_TX_READY_BIT   = 0;
    localparam int unsigned STAT_RX_READY_BIT   = 1;
    localparam int unsigned STAT_TAPE_READY_BIT = 2;

    // Values after reset
    localparam logic [7:0] RESET_ZERO        = 8'h00;
    localparam logic [7:0] STATUS_LOW_RESET  = 8'h05;
    localparam logic [7:0] STATUS_HIGH_RESET = 8'h01;

    // Length of the internal reset sequence in clock cycles
    localparam logic [3:0] RESET_SEQ_CYCLES  = 4'h8;

    // Reset sequencer states, Gray coded from RST_IDLE through RST_RUN to RST_DONE
    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_RUN  = 2'b01,
        RST_DONE = 2'b11
    } reset_state_t;

endpackage
